// ---- lspc_pkg.sv ----
package lspc_pkg;

	localparam int LSPC_ADDR_W = 5;
	localparam int LSPC_DATA_W = 8;

	// Register offsets.
	localparam logic [4:0] LSPC_OFS_SYS_CTRL    = 5'h00;
	localparam logic [4:0] LSPC_OFS_LAMP_CTRL   = 5'h02;
	localparam logic [4:0] LSPC_OFS_LAMP_FAULT  = 5'h04;
	localparam logic [4:0] LSPC_OFS_EVENT_FLAGS = 5'h06;
	localparam logic [4:0] LSPC_OFS_EVENT_MASK  = 5'h07;
	localparam logic [4:0] LSPC_OFS_SYS_STATUS  = 5'h0C;

	// system_control fields.
	localparam int LSPC_SC_STOP      = 0;
	localparam int LSPC_SC_SLEEP     = 1;
	localparam int LSPC_SC_SLEW_LO   = 2;
	localparam int LSPC_SC_SLEW_HI   = 3;
	localparam int LSPC_SC_OT_UPPER  = 4;
	localparam int LSPC_SC_OT_LOWER  = 5;
	localparam int LSPC_SC_VSD       = 6;
	localparam int LSPC_SC_PSE       = 7;

	// lamp_output_control fields.
	localparam int LSPC_LC_FORCE_LO  = 0;
	localparam int LSPC_LC_PWM_LO    = 3;
	localparam int LSPC_LC_AUX_ON    = 6;

	// lamp_output_fault_status fields.
	localparam int LSPC_LF_OC_LO     = 0;
	localparam int LSPC_LF_AUX_OC    = 7;

	// Event flag and mask fields.
	localparam int LSPC_EV_LOW_V     = 0;
	localparam int LSPC_EV_HIGH_V    = 1;
	localparam int LSPC_EV_OT_WARN   = 2;

	// system_status fields.
	localparam int LSPC_SS_LIN_CL    = 0;
	localparam int LSPC_SS_OT_WARN   = 1;
	localparam int LSPC_SS_SUP_FAULT = 2;
	localparam int LSPC_SS_AUX_FAIL  = 3;
	localparam int LSPC_SS_LAMP_FAIL = 4;

	localparam logic [7:0] LSPC_RST_BYTE = 8'h00;

	// Slew select codes.
	localparam logic [1:0] LSPC_SLEW_INIT_20K = 2'h0;
	localparam logic [1:0] LSPC_SLEW_FAST_8X  = 2'h1;
	localparam logic [1:0] LSPC_SLEW_SLOW_10K = 2'h2;
	localparam logic [1:0] LSPC_SLEW_FAST_4X  = 2'h3;

	// Timing.
	localparam int LSPC_CLK_PERIOD_NS   = 100;
	localparam int LSPC_LIN_CL_TIME_US  = 100;
	localparam int LSPC_LIN_CL_CYCLES   = (LSPC_LIN_CL_TIME_US * 1000) / LSPC_CLK_PERIOD_NS;
	localparam int LSPC_SYNC_IN_W       = 10;

endpackage : lspc_pkg

// ---- lspc_ctrl.sv ----
`timescale 1ns/1ps

// Behaviour
// - Low or high voltage flag with shutdown enabled turns lamp switches off.
// - Write one clears voltage flags, ignored while the condition is still present.
// - Over-temperature warning sets a flag; interrupt only when its mask bit is set.
// - Warning flag with upper disable clear stops lamps and bridge upper FETs.
// - Warning flag with lower disable clear stops bridge lower FETs.
// - Write one clears warning flag, ignored while over-temperature persists.
// - With first-threshold shutdown disabled, reset threshold kills every power stage.
// - Lamp over-current switches that output off and sets its fault flag.
// - While limiting after a trip, each PWM rising edge re-enables the driver.
// - While limiting, on-time depends only on rising edges and trips, not duty.
// - Aux supply on only with power stage enable and aux on both set.
// - Voltage flags never affect the aux supply output.
// - Aux over-current limits current and sets aux fault flag, no shutdown.
// - Force-on bit turns its lamp on until an over-current trip; reset clears.
// - Follow bit makes the lamp track the PWM level; reset clears.
// - Lamp fault flags at bits 0-2, write one clears, zero ignored.
// - Aux fault flag at bit 7, write one clears, zero ignored.
// - Power stage enable low keeps all gated stages off; reset clears it.
// - Stop or sleep taken only with bits 7-2 zero; reset or interrupt clears.
// - Two-bit slew field selects 20k, 8x, 10k or 4x; resets to 00.
// - LIN current limit status tracks limiting; transmitter cut after a timeout.
// - Supply fault status is OR of voltage flags; status mirrors warning flag.
// - Force plus follow runs inrush limiting: flag set, output kept on.
module lspc_ctrl
	import lspc_pkg::*;
#(
	parameter int LIN_CL_CYCLES = LSPC_LIN_CL_CYCLES
) (
	input  wire logic                   ref_clk,
	input  wire logic                   arst_n,
	input  wire logic [LSPC_ADDR_W-1:0] reg_addr,
	input  wire logic [LSPC_DATA_W-1:0] reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output logic      [LSPC_DATA_W-1:0] reg_rdata,
	input  wire logic                   pwm_in,
	input  wire logic                   low_voltage_det,
	input  wire logic                   high_voltage_det,
	input  wire logic                   overtemp_warn_det,
	input  wire logic                   overtemp_reset_det,
	input  wire logic [2:0]             lamp_oc_det,
	input  wire logic                   aux_oc_det,
	input  wire logic                   lin_cl_det,
	input  wire logic                   cpu_irq_req,
	output logic      [2:0]             lamp_switch_en,
	output logic                        bridge_upper_en,
	output logic                        bridge_lower_en,
	output logic                        aux_supply_en,
	output logic                        aux_current_limit,
	output logic                        h0_en,
	output logic                        lin_tx_en,
	output logic                        current_source_en,
	output logic      [1:0]             lin_slew_sel,
	output logic                        stop_req,
	output logic                        sleep_req,
	output logic                        overtemp_irq
);

	// Input synchronisers: three stages, a change is accepted once stages two and three agree.
	logic [LSPC_SYNC_IN_W-1:0] async_in;
	logic [LSPC_SYNC_IN_W-1:0] sync1_reg;
	logic [LSPC_SYNC_IN_W-1:0] sync2_reg;
	logic [LSPC_SYNC_IN_W-1:0] sync3_reg;
	logic [LSPC_SYNC_IN_W-1:0] filt_reg;

	assign async_in = {pwm_in, lin_cl_det, aux_oc_det, lamp_oc_det, overtemp_reset_det,
		overtemp_warn_det, high_voltage_det, low_voltage_det};

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			sync3_reg <= '0;
			filt_reg  <= '0;
		end else begin
			sync1_reg <= async_in;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			filt_reg  <= (sync2_reg & sync3_reg) | (filt_reg & (sync2_reg | sync3_reg));
		end
	end

	logic       lv_s;
	logic       hv_s;
	logic       otw_s;
	logic       otr_s;
	logic [2:0] loc_s;
	logic       aoc_s;
	logic       lcl_s;
	logic       pwm_s;
	logic       pwm_d_reg;
	logic       pwm_rise;

	assign {pwm_s, lcl_s, aoc_s, loc_s, otr_s, otw_s, hv_s, lv_s} = filt_reg;
	assign pwm_rise = pwm_s & ~pwm_d_reg;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pwm_d_reg <= 1'b0;
		end else begin
			pwm_d_reg <= pwm_s;
		end
	end

	// Register strobes.
	logic wr_sys;
	logic wr_lamp;
	logic wr_fault;
	logic wr_ev;
	logic wr_mask;

	assign wr_sys   = reg_wr && (reg_addr == LSPC_OFS_SYS_CTRL);
	assign wr_lamp  = reg_wr && (reg_addr == LSPC_OFS_LAMP_CTRL);
	assign wr_fault = reg_wr && (reg_addr == LSPC_OFS_LAMP_FAULT);
	assign wr_ev    = reg_wr && (reg_addr == LSPC_OFS_EVENT_FLAGS);
	assign wr_mask  = reg_wr && (reg_addr == LSPC_OFS_EVENT_MASK);

	// system_control.
	logic [7:0] sys_ctrl_reg;
	logic       cmd_ok;
	logic       pse;
	logic       vsd;
	logic       ot_dis_up;
	logic       ot_dis_lo;

	assign cmd_ok    = (reg_wdata[7:2] == 6'h00);
	assign pse       = sys_ctrl_reg[LSPC_SC_PSE];
	assign vsd       = sys_ctrl_reg[LSPC_SC_VSD];
	assign ot_dis_up = sys_ctrl_reg[LSPC_SC_OT_UPPER];
	assign ot_dis_lo = sys_ctrl_reg[LSPC_SC_OT_LOWER];

	// A pending interrupt request aborts a command written in the same cycle; the stop and sleep bits stay clear.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sys_ctrl_reg <= LSPC_RST_BYTE;
		end else begin
			if (wr_sys) begin
				sys_ctrl_reg[7:2] <= reg_wdata[7:2];
			end
			if (cpu_irq_req) begin
				sys_ctrl_reg[1:0] <= 2'b00;
			end else if (wr_sys) begin
				sys_ctrl_reg[1:0] <= cmd_ok ? reg_wdata[1:0] : 2'b00;
			end
		end
	end

	// lamp_output_control.
	logic [7:0] lamp_ctrl_reg;
	logic [2:0] force_on;
	logic [2:0] follow_pwm;
	logic       aux_on;

	assign force_on   = lamp_ctrl_reg[LSPC_LC_FORCE_LO +: 3];
	assign follow_pwm = lamp_ctrl_reg[LSPC_LC_PWM_LO +: 3];
	assign aux_on     = lamp_ctrl_reg[LSPC_LC_AUX_ON];

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			lamp_ctrl_reg <= LSPC_RST_BYTE;
		end else if (wr_lamp) begin
			lamp_ctrl_reg <= {1'b0, reg_wdata[6:0]};
		end
	end

	// Fault flags: hardware set wins over a write-one clear.
	logic [2:0] lamp_oc_flag_reg;
	logic       aux_oc_flag_reg;
	logic       lv_flag_reg;
	logic       hv_flag_reg;
	logic       ot_flag_reg;
	logic       ot_mask_reg;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			lamp_oc_flag_reg <= 3'b000;
			aux_oc_flag_reg  <= 1'b0;
		end else begin
			lamp_oc_flag_reg <= (lamp_oc_flag_reg & ~({3{wr_fault}} & reg_wdata[LSPC_LF_OC_LO +: 3]))
				| (loc_s & (force_on | follow_pwm));
			aux_oc_flag_reg  <= (aux_oc_flag_reg & ~(wr_fault & reg_wdata[LSPC_LF_AUX_OC]))
				| aoc_s;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			lv_flag_reg <= 1'b0;
			hv_flag_reg <= 1'b0;
			ot_flag_reg <= 1'b0;
		end else begin
			// Clears are masked while the condition persists; the condition also re-sets the flag.
			lv_flag_reg <= (lv_flag_reg & ~(wr_ev & reg_wdata[LSPC_EV_LOW_V] & ~lv_s)) | lv_s;
			hv_flag_reg <= (hv_flag_reg & ~(wr_ev & reg_wdata[LSPC_EV_HIGH_V] & ~hv_s)) | hv_s;
			ot_flag_reg <= (ot_flag_reg & ~(wr_ev & reg_wdata[LSPC_EV_OT_WARN] & ~otw_s)) | otw_s;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ot_mask_reg <= 1'b0;
		end else if (wr_mask) begin
			ot_mask_reg <= reg_wdata[LSPC_EV_OT_WARN];
		end
	end

	// Protection gates.
	logic volt_kill;
	logic ot_up_kill;
	logic ot_lo_kill;
	logic all_kill;

	assign volt_kill  = (lv_flag_reg | hv_flag_reg) & ~vsd;
	assign ot_up_kill = ot_flag_reg & ~ot_dis_up;
	assign ot_lo_kill = ot_flag_reg & ~ot_dis_lo;
	assign all_kill   = otr_s & ot_dis_up;

	// Per-lamp drive. A trip in follow mode enters limiting, where the output is re-armed by each
	// rising PWM edge and stays on until the next trip whatever the duty; limiting ends when
	// software clears the fault flag.
	logic [2:0] limiting_reg;
	logic [2:0] tripped_reg;
	logic [2:0] lamp_on;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			limiting_reg <= 3'b000;
			tripped_reg  <= 3'b000;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (!(follow_pwm[i] && !force_on[i]) || !lamp_oc_flag_reg[i] && !loc_s[i]) begin
					limiting_reg[i] <= 1'b0;
					tripped_reg[i]  <= 1'b0;
				end else if (loc_s[i]) begin
					limiting_reg[i] <= 1'b1;
					tripped_reg[i]  <= 1'b1;
				end else if (pwm_rise) begin
					tripped_reg[i]  <= 1'b0;
				end
			end
		end
	end

	always_comb begin
		for (int i = 0; i < 3; i++) begin
			unique case ({follow_pwm[i], force_on[i]})
				2'b00: lamp_on[i] = 1'b0;
				2'b01: lamp_on[i] = ~lamp_oc_flag_reg[i] & ~loc_s[i];
				2'b10: lamp_on[i] = limiting_reg[i] ? ~tripped_reg[i] & ~loc_s[i]
					: pwm_s & ~loc_s[i];
				2'b11: lamp_on[i] = 1'b1;
			endcase
		end
	end

	// LIN transmitter cut-off after a long stay in current limitation.
	logic [$clog2(LIN_CL_CYCLES+1)-1:0] lin_cl_cnt_reg;
	logic                               lin_off_reg;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			lin_cl_cnt_reg <= '0;
			lin_off_reg    <= 1'b0;
		end else if (!lcl_s) begin
			lin_cl_cnt_reg <= '0;
			lin_off_reg    <= 1'b0;
		end else if (lin_cl_cnt_reg == LIN_CL_CYCLES[$clog2(LIN_CL_CYCLES+1)-1:0] - 1'b1) begin
			lin_off_reg    <= 1'b1;
		end else begin
			lin_cl_cnt_reg <= lin_cl_cnt_reg + 1'b1;
		end
	end

	// Registered outputs.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			lamp_switch_en    <= 3'b000;
			bridge_upper_en   <= 1'b0;
			bridge_lower_en   <= 1'b0;
			aux_supply_en     <= 1'b0;
			aux_current_limit <= 1'b0;
			h0_en             <= 1'b0;
			lin_tx_en         <= 1'b0;
			current_source_en <= 1'b0;
			overtemp_irq      <= 1'b0;
		end else begin
			lamp_switch_en    <= lamp_on & {3{pse & ~volt_kill & ~ot_up_kill & ~all_kill}};
			bridge_upper_en   <= pse & ~ot_up_kill & ~all_kill;
			bridge_lower_en   <= pse & ~ot_lo_kill & ~all_kill;
			aux_supply_en     <= pse & aux_on & ~all_kill;
			aux_current_limit <= aoc_s & pse & aux_on;
			h0_en             <= pse & ~all_kill;
			lin_tx_en         <= pse & ~lin_off_reg & ~all_kill;
			current_source_en <= pse & ~all_kill;
			overtemp_irq      <= ot_flag_reg & ot_mask_reg;
		end
	end

	assign lin_slew_sel = sys_ctrl_reg[LSPC_SC_SLEW_HI:LSPC_SC_SLEW_LO];
	assign stop_req     = sys_ctrl_reg[LSPC_SC_STOP];
	assign sleep_req    = sys_ctrl_reg[LSPC_SC_SLEEP];

	// Read path: data one cycle after the strobe, zero for unmapped offsets.
	logic [7:0] sys_status;
	logic [7:0] rd_mux;

	always_comb begin
		sys_status = 8'h00;
		sys_status[LSPC_SS_LIN_CL]    = lcl_s;
		sys_status[LSPC_SS_OT_WARN]   = ot_flag_reg;
		sys_status[LSPC_SS_SUP_FAULT] = lv_flag_reg | hv_flag_reg;
		sys_status[LSPC_SS_AUX_FAIL]  = aux_oc_flag_reg;
		sys_status[LSPC_SS_LAMP_FAIL] = |lamp_oc_flag_reg;
		unique case (reg_addr)
			LSPC_OFS_SYS_CTRL:    rd_mux = sys_ctrl_reg;
			LSPC_OFS_LAMP_CTRL:   rd_mux = lamp_ctrl_reg;
			LSPC_OFS_LAMP_FAULT:  rd_mux = {aux_oc_flag_reg, 4'h0, lamp_oc_flag_reg};
			LSPC_OFS_EVENT_FLAGS: rd_mux = {5'h00, ot_flag_reg, hv_flag_reg, lv_flag_reg};
			LSPC_OFS_EVENT_MASK:  rd_mux = {5'h00, ot_mask_reg, 2'b00};
			LSPC_OFS_SYS_STATUS:  rd_mux = sys_status;
			default:              rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rd_mux;
		end
	end

	// Checks.
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	AST_VOLT_OFF: assert property ((lv_flag_reg || hv_flag_reg) && !vsd |=> lamp_switch_en == 3'b000)
		else $error("Lamp on during voltage shutdown.");
	AST_VOLT_CLR_HELD: assert property (wr_ev && reg_wdata[0] && lv_s |=> lv_flag_reg)
		else $error("Low voltage flag cleared while condition present.");
	AST_OT_IRQ: assert property (ot_flag_reg && ot_mask_reg |=> overtemp_irq)
		else $error("Over-temperature interrupt missing.");
	AST_OT_UPPER: assert property (ot_flag_reg && !ot_dis_up |=> !bridge_upper_en && lamp_switch_en == 3'b000)
		else $error("Upper stages on during over-temperature.");
	AST_OT_LOWER: assert property (ot_flag_reg && !ot_dis_lo |=> !bridge_lower_en)
		else $error("Lower stages on during over-temperature.");
	AST_OT_RESET: assert property (otr_s && ot_dis_up |=> !aux_supply_en && !h0_en && !bridge_lower_en)
		else $error("Power stage on past reset threshold.");
	AST_LAMP_TRIP: assert property (loc_s[0] && force_on[0] && !follow_pwm[0]
		|=> lamp_oc_flag_reg[0] && !lamp_switch_en[0] ##1 !lamp_switch_en[0])
		else $error("Lamp not tripped on over-current.");
	AST_PSE_GATE: assert property (!pse |=> !aux_supply_en && !lin_tx_en && lamp_switch_en == 3'b000)
		else $error("Stage on without power stage enable.");
	AST_CMD_REFUSE: assert property (wr_sys && !cmd_ok |=> !stop_req && !sleep_req)
		else $error("Mode command taken with other bits set.");
	AST_SET_WINS: assert property (wr_fault && reg_wdata[1] && loc_s[1] && follow_pwm[1] |=> lamp_oc_flag_reg[1])
		else $error("Fault set lost to clear.");
	AST_LIN_CUT: assert property ($rose(lin_off_reg) |-> $past(lcl_s, 1) && lin_cl_cnt_reg != 0)
		else $error("LIN cut without current limitation.");
	AST_AUX_GATE: assert property (!(pse && aux_on) |=> !aux_supply_en)
		else $error("Aux supply on without both enables.");
	AST_INRUSH_REARM: assert property (limiting_reg[1] && tripped_reg[1] && pwm_rise && !loc_s[1] |=> !tripped_reg[1])
		else $error("Lamp not re-armed by PWM rising edge.");

	COV_INRUSH: cover property (limiting_reg[1] && tripped_reg[1] ##1 pwm_rise ##1 !tripped_reg[1]);
	COV_STOP: cover property (wr_sys && cmd_ok && reg_wdata[0] ##1 stop_req);
	COV_OT_SHUT: cover property (ot_flag_reg && !ot_dis_up ##1 !bridge_upper_en);
	COV_VOLT_CLR: cover property (lv_flag_reg ##1 wr_ev && reg_wdata[0] && !lv_s ##1 !lv_flag_reg);

endmodule : lspc_ctrl

// ---- lspc_mcu_model.sv ----
`timescale 1ns/1ps

// Stands in for the microcontroller's PWM pin; it only ever changes just after a clock edge.
module lspc_mcu_model #(
	parameter int HALF_PERIOD = 6
) (
	input  wire logic ref_clk,
	input  wire logic arst_n,
	input  wire logic run,
	input  wire logic level,
	output logic      pwm_in
);
	logic [7:0] cnt_reg;

	// Free-running square wave while run is high, else a static level the bench picks.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg <= 8'h00;
			pwm_in  <= 1'b0;
		end else if (!run) begin
			cnt_reg <= 8'h00;
			pwm_in  <= level;
		end else if (cnt_reg == 8'(HALF_PERIOD - 1)) begin
			cnt_reg <= 8'h00;
			pwm_in  <= ~pwm_in;
		end else begin
			cnt_reg <= cnt_reg + 8'h01;
		end
	end
endmodule : lspc_mcu_model

// ---- tb.sv ----
`timescale 1ns/1ps

module tb;
	import lspc_pkg::*;
	localparam int CL_N = 8;
	logic       ref_clk, arst_n, reg_wr, reg_rd, low_v, high_v, ot_warn, ot_rst, aux_oc, lin_cl, irq_req;
	logic       run, level, pwm_in, upper, lower, aux_en, aux_cl, h0, lin_tx, cs_en, stop_req, sleep_req, ot_irq;
	logic [4:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, d;
	logic [2:0] lamp_oc, lamp;
	logic [1:0] slew;
	int         n_fail, check_count, seed, cycles;

	lspc_mcu_model #(.HALF_PERIOD(6)) mcu (.ref_clk(ref_clk), .arst_n(arst_n), .run(run), .level(level),
		.pwm_in(pwm_in));

	lspc_ctrl #(.LIN_CL_CYCLES(CL_N)) dut (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwm_in(pwm_in),
		.low_voltage_det(low_v), .high_voltage_det(high_v), .overtemp_warn_det(ot_warn),
		.overtemp_reset_det(ot_rst), .lamp_oc_det(lamp_oc), .aux_oc_det(aux_oc), .lin_cl_det(lin_cl),
		.cpu_irq_req(irq_req), .lamp_switch_en(lamp), .bridge_upper_en(upper), .bridge_lower_en(lower),
		.aux_supply_en(aux_en), .aux_current_limit(aux_cl), .h0_en(h0), .lin_tx_en(lin_tx),
		.current_source_en(cs_en), .lin_slew_sel(slew), .stop_req(stop_req), .sleep_req(sleep_req),
		.overtemp_irq(ot_irq));

	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	task conclude();
		$display("checks %0d, mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : conclude

	// The ceiling leaves ample room over the few hundred cycles the sequence needs.
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_fail++;
			conclude();
		end
	end

	task chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask : chk8

	task chkb(input logic got, input logic exp, input string what);
		chk8({7'h00, got}, {7'h00, exp}, what);
	endtask : chkb

	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc

	task wr(input logic [4:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task rd_chk(input logic [4:0] a, input logic [7:0] exp, input string what);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk8(reg_rdata, exp, what);
	endtask : rd_chk

	function automatic logic [7:0] status(input logic lcl, input logic ot, input logic vf, input logic ax,
		input logic lf);
		return {3'h0, lf, ax, vf, ot, lcl};
	endfunction : status

	task done_test(input string name);
		$display("test %s finished, mismatches so far %0d", name, n_fail);
	endtask : done_test

	initial begin
		{reg_wr, reg_rd, low_v, high_v, ot_warn, ot_rst, aux_oc, lin_cl, irq_req, run, level} = '0;
		reg_addr = 5'h00;
		reg_wdata = 8'h00;
		lamp_oc = 3'h0;
		n_fail = 0;
		check_count = 0;
		cycles = 0;
		seed = 53702;
		arst_n = 1'b0;
		repeat (6) @(posedge ref_clk);
		arst_n <= 1'b1;
		chk8({lamp, aux_en, upper, lower, lin_tx, cs_en}, 8'h00, "outputs in reset");
		rd_chk(LSPC_OFS_SYS_CTRL, 8'h00, "ctrl reset");
		rd_chk(LSPC_OFS_LAMP_CTRL, 8'h00, "lamp ctrl reset");
		rd_chk(LSPC_OFS_LAMP_FAULT, 8'h00, "fault reset");
		rd_chk(LSPC_OFS_SYS_STATUS, 8'h00, "status reset");
		wr(5'h1F, 8'hFF);
		rd_chk(5'h1F, 8'h00, "unmapped");
		done_test("reset");
		for (int i = 0; i < 4; i++) begin
			wr(LSPC_OFS_SYS_CTRL, 8'h80 | 8'(i << 2));
			cyc(1);
			chk8({6'h00, slew}, 8'(i), "slew output");
			rd_chk(LSPC_OFS_SYS_CTRL, 8'h80 | 8'(i << 2), "slew readback");
		end
		chk8({3'h0, upper, lower, lin_tx, cs_en, 1'b0}, 8'h1E, "power stages on");
		for (int k = 0; k < 2; k++) begin
			wr(LSPC_OFS_SYS_CTRL, 8'h04 | 8'(1 << k));
			cyc(1);
			chk8({6'h00, sleep_req, stop_req}, 8'h00, "command with high bits");
			wr(LSPC_OFS_SYS_CTRL, 8'(1 << k));
			cyc(1);
			chk8({6'h00, sleep_req, stop_req}, 8'(1 << k), "command taken");
			irq_req <= 1'b1;
			@(posedge ref_clk);
			irq_req <= 1'b0;
			cyc(1);
			chk8({6'h00, sleep_req, stop_req}, 8'h00, "command cleared");
		end
		done_test("control");
		for (int i = 0; i < 6; i++) begin
			d = (i == 0) ? 8'hFF : 8'($random(seed));
			wr(LSPC_OFS_SYS_CTRL, 8'h80);
			wr(LSPC_OFS_LAMP_CTRL, d);
			rd_chk(LSPC_OFS_LAMP_CTRL, d & 8'h7F, "lamp ctrl readback");
			cyc(2);
			chk8({4'h0, aux_en, lamp}, {4'h0, d[6], d[2:0]}, "force and aux");
			wr(LSPC_OFS_SYS_CTRL, 8'h00);
			cyc(2);
			chk8({4'h0, aux_en, lamp}, 8'h00, "gated off");
		end
		wr(LSPC_OFS_SYS_CTRL, 8'h80);
		wr(LSPC_OFS_LAMP_CTRL, 8'h08);
		level <= 1'b1;
		cyc(8);
		chkb(lamp[0], 1'b1, "follow high");
		level <= 1'b0;
		cyc(8);
		chkb(lamp[0], 1'b0, "follow low");
		done_test("modes");
		wr(LSPC_OFS_LAMP_CTRL, 8'h41);
		lamp_oc <= 3'h1;
		cyc(8);
		chkb(lamp[0], 1'b0, "lamp trip");
		rd_chk(LSPC_OFS_SYS_STATUS, status(0, 0, 0, 0, 1), "lamp fail status");
		lamp_oc <= 3'h0;
		cyc(8);
		wr(LSPC_OFS_LAMP_FAULT, 8'h00);
		rd_chk(LSPC_OFS_LAMP_FAULT, 8'h01, "zero write kept flag");
		chkb(lamp[0], 1'b0, "stays off");
		wr(LSPC_OFS_LAMP_FAULT, 8'h01);
		rd_chk(LSPC_OFS_LAMP_FAULT, 8'h00, "lamp flag cleared");
		chkb(lamp[0], 1'b1, "lamp re-enabled");
		aux_oc <= 1'b1;
		cyc(8);
		chk8({6'h00, aux_en, aux_cl}, 8'h03, "aux limited not off");
		rd_chk(LSPC_OFS_LAMP_FAULT, 8'h80, "aux flag");
		rd_chk(LSPC_OFS_SYS_STATUS, status(0, 0, 0, 1, 0), "aux fail status");
		aux_oc <= 1'b0;
		cyc(8);
		wr(LSPC_OFS_LAMP_FAULT, 8'h7F);
		rd_chk(LSPC_OFS_LAMP_FAULT, 8'h80, "aux zero write");
		wr(LSPC_OFS_LAMP_FAULT, 8'h80);
		rd_chk(LSPC_OFS_LAMP_FAULT, 8'h00, "aux cleared");
		chkb(aux_cl, 1'b0, "aux limit off");
		done_test("overcurrent");
		for (int k = 0; k < 2; k++) begin
			wr(LSPC_OFS_SYS_CTRL, 8'h80 | 8'(k << 6));
			if (k == 0) low_v <= 1'b1;
			else high_v <= 1'b1;
			cyc(8);
			chk8({6'h00, aux_en, lamp[0]}, {6'h00, 1'b1, 1'(k)}, "voltage fault outputs");
			rd_chk(LSPC_OFS_EVENT_FLAGS, 8'(1 << k), "voltage flag");
			rd_chk(LSPC_OFS_SYS_STATUS, status(0, 0, 1, 0, 0), "supply fault");
			wr(LSPC_OFS_EVENT_FLAGS, 8'(1 << k));
			rd_chk(LSPC_OFS_EVENT_FLAGS, 8'(1 << k), "clear while present");
			{low_v, high_v} <= 2'b00;
			cyc(8);
			wr(LSPC_OFS_EVENT_FLAGS, 8'(1 << k));
			rd_chk(LSPC_OFS_EVENT_FLAGS, 8'h00, "voltage flag cleared");
			cyc(1);
			chkb(lamp[0], 1'b1, "lamp back");
		end
		wr(LSPC_OFS_EVENT_MASK, 8'h04);
		wr(LSPC_OFS_SYS_CTRL, 8'hA0);
		ot_warn <= 1'b1;
		cyc(8);
		chk8({4'h0, ot_irq, upper, lower, lamp[0]}, 8'h0A, "warning shutdown");
		rd_chk(LSPC_OFS_SYS_STATUS, status(0, 1, 0, 0, 0), "warning mirror");
		wr(LSPC_OFS_EVENT_FLAGS, 8'h04);
		rd_chk(LSPC_OFS_EVENT_FLAGS, 8'h04, "warning clear ignored");
		ot_warn <= 1'b0;
		cyc(8);
		wr(LSPC_OFS_EVENT_MASK, 8'h00);
		cyc(2);
		chkb(ot_irq, 1'b0, "masked interrupt");
		wr(LSPC_OFS_EVENT_FLAGS, 8'h04);
		cyc(2);
		chk8({5'h00, upper, lower, lamp[0]}, 8'h07, "warning cleared");
		wr(LSPC_OFS_SYS_CTRL, 8'h90);
		ot_warn <= 1'b1;
		cyc(8);
		chk8({5'h00, upper, lower, lamp[0]}, 8'h05, "upper shutdown disabled");
		ot_rst <= 1'b1;
		cyc(8);
		chk8({2'h0, upper, lamp[0], aux_en, h0, lin_tx, cs_en}, 8'h00, "reset threshold kill");
		{ot_warn, ot_rst} <= 2'b00;
		cyc(8);
		wr(LSPC_OFS_EVENT_FLAGS, 8'h04);
		wr(LSPC_OFS_SYS_CTRL, 8'h80);
		done_test("protection");
		lin_cl <= 1'b1;
		cyc(6);
		chkb(lin_tx, 1'b1, "lin before timeout");
		rd_chk(LSPC_OFS_SYS_STATUS, status(1, 0, 0, 0, 0), "lin limit status");
		cyc(CL_N + 4);
		chkb(lin_tx, 1'b0, "lin cut");
		lin_cl <= 1'b0;
		cyc(8);
		chkb(lin_tx, 1'b1, "lin restored");
		wr(LSPC_OFS_LAMP_CTRL, 8'h50);
		level <= 1'b1;
		cyc(8);
		for (int t = 0; t < 2; t++) begin
			lamp_oc <= 3'h2;
			cyc(8);
			chkb(lamp[1], 1'b0, "inrush trip");
			lamp_oc <= 3'h0;
			level <= 1'b0;
			cyc(8);
			level <= 1'b1;
			cyc(8);
			chkb(lamp[1], 1'b1, "rising edge re-enable");
			level <= 1'b0;
			cyc(8);
			chkb(lamp[1], 1'b1, "on despite low pwm");
		end
		wr(LSPC_OFS_LAMP_FAULT, 8'h07);
		wr(LSPC_OFS_LAMP_CTRL, 8'h12);
		run <= 1'b1;
		lamp_oc <= 3'h2;
		cyc(8);
		chkb(lamp[1], 1'b1, "limiting keeps output");
		rd_chk(LSPC_OFS_LAMP_FAULT, 8'h02, "limiting sets flag");
		lamp_oc <= 3'h0;
		run <= 1'b0;
		done_test("inrush");
		conclude();
	end
endmodule : tb
